// ==== include/flash_ctl_defines.svh ====
`ifndef FLASH_CTL_DEFINES_SVH
`define FLASH_CTL_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_CLK_DIV 4'h0
`define IDX_CONFIG 4'h3
`define IDX_PROTECT 4'h4
`define IDX_STATUS 4'h5
`define IDX_COMMAND 4'h6
`define IDX_RESERVED 4'h7

// address bit that selects the flash array window
`define FLASH_SPACE_BIT 12

// status bit positions
`define ST_BUF_EMPTY 7
`define ST_COMPLETE 6
`define ST_PROT_VIOL 5
`define ST_ACC_ERR 4
`define ST_BLANK 2
`define ST_FAIL 1
`define ST_DONE 0

// configuration bit positions
`define CFG_BUF_EMPTY_IE 7
`define CFG_COMPLETE_IE 6

// protection bit positions
`define PR_OPEN_POL 7
`define PR_HIGH_DIS 5
`define PR_LOW_DIS 2

// command code: writable bits and accepted codes
`define CMD_MASK 8'h65
`define CMD_ERASE_VERIFY 8'h05
`define CMD_WORD_PROGRAM 8'h20
`define CMD_SECTOR_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41

// reset values
`define RST_PROTECT 8'hFF
`define RST_CONFIG 8'h00
`define RST_CLK_DIV 7'h00

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== include/flash_ctl_pkg.sv ====
package flash_ctl_pkg;

	// command write sequence progress
	typedef enum logic [1:0] {
		seq_idle,
		seq_addr,
		seq_cmd
	} seq_e;

	// protection scenario index
	typedef logic [2:0] scenario_t;

endpackage : flash_ctl_pkg

// ==== logic/flash_cmd_status_protect.sv ====
// Contract
// - protection may only stay the same or become more restrictive
// - refused protection writes leave the register; it reads the active one
// - allowed moves: 0->0123, 1->13, 2->23, 3->3, 4->34, 5->2345
// - normal modes: empty, violation, error writable; complete, blank read-only
// - special modes: fail writable, done read-only; software clears fail first
// - empty flag bit 7 reads one when buffers free; write one clears
// - writing zero to empty flag mid-sequence aborts and sets access error
// - writing zero to empty flag outside a sequence sets no error
// - interrupt while empty flag and its enable are both set
// - complete flag bit 6 clears with empty flag, sets when all done
// - complete flag stays clear when a buffered command follows directly
// - interrupt while complete flag and its enable are both set
// - violation flag bit 5 sets on protected program or erase; one clears
// - no launch while violation flag is set
// - access error bit 4: sequence fault, bad code, stop while busy
// - no launch while access error set; writing zero has no effect
// - blank bit 2 sets on erased verify; cleared by a valid launch
// - special modes: fail bit 1 sets on failed verify; blocks launches
// - special modes: done bit 0 reads zero while an operation runs
// - command register keeps only bits 6, 5, 2 and 0
// - accepted codes: 05 verify, 20 program, 40 sector, 41 mass erase
// - any other code sets access error and runs nothing
// - no launch and access error if divider never written
`timescale 1ns/1ps
`include "flash_ctl_defines.svh"

module flash_cmd_status_protect (
	input wire logic clk_sys, // 50 MHz bus clock
	input wire logic rst_n, // async reset, active low
	input wire logic [12:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [12:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic special_mode, // high in special modes
	input wire logic stop_req, // processor stop instruction pulse
	input wire logic prot_hit, // seq_addr_out lies in protected range
	input wire logic op_done, // engine finished active operation
	input wire logic verify_blank, // with op_done: array is erased
	output logic op_start, // pulse: operation handed to engine
	output logic [7:0] op_code, // code of active operation
	output logic [12:0] op_addr, // address of active operation
	output logic [31:0] op_data, // data of active operation
	output logic op_active, // engine owns an operation
	output logic [12:0] seq_addr_out, // address captured by sequence
	output logic [7:0] protection_config, // active protection byte
	output logic irq // interrupt request
);

	logic rst_m_n;
	logic rst_s_n;
	// release reset through two flops so all logic leaves reset together
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_n <= 1'b0;
			rst_s_n <= 1'b0;
		end else begin
			rst_m_n <= 1'b1;
			rst_s_n <= rst_m_n;
		end
	end

	logic aw_held;
	logic w_held;
	logic [12:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	// address and data are taken independently, in either order
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 13'h0000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	logic [3:0] wr_idx;
	logic wr_reg;
	logic wr_lane0;
	logic flash_wr;
	logic wr_mapped;
	assign wr_idx = aw_addr[5:2];
	assign wr_reg = wr_fire && !aw_addr[`FLASH_SPACE_BIT]
		&& (aw_addr[11:6] == 6'h00);
	assign wr_lane0 = wr_reg && w_strb[0];
	// only an aligned full word counts as a flash array write
	assign flash_wr = wr_fire && aw_addr[`FLASH_SPACE_BIT]
		&& (aw_addr[1:0] == 2'h0) && (w_strb == 4'hF);
	assign wr_mapped = aw_addr[`FLASH_SPACE_BIT] || (wr_reg
		&& (wr_idx == `IDX_CLK_DIV || wr_idx == `IDX_CONFIG
		|| wr_idx == `IDX_PROTECT || wr_idx == `IDX_STATUS
		|| wr_idx == `IDX_COMMAND || wr_idx == `IDX_RESERVED));

	// write response; unmapped addresses answer slave error
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	logic st_wr;
	logic cmd_wr;
	logic other_wr;
	logic [7:0] wb;
	assign wb = w_data[7:0];
	assign st_wr = wr_lane0 && wr_idx == `IDX_STATUS;
	assign cmd_wr = wr_lane0 && wr_idx == `IDX_COMMAND;
	assign other_wr = wr_lane0 && !st_wr && !cmd_wr;

	// status flags
	logic buf_empty_flag;
	logic command_complete_flag;
	logic protect_violation_flag;
	logic access_error_flag;
	logic blank_flag;
	logic fail_flag;
	logic [7:0] flash_config_reg;
	logic [6:0] flash_clock_divider;
	logic div_loaded;
	logic [7:0] command_code_reg;
	flash_ctl_pkg::seq_e seq_state;
	logic [31:0] seq_data;

	// clock divider store; only the fact it was written matters here
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			flash_clock_divider <= `RST_CLK_DIV;
			div_loaded <= 1'b0;
		end else if (wr_lane0 && wr_idx == `IDX_CLK_DIV) begin
			flash_clock_divider <= wb[6:0];
			div_loaded <= 1'b1;
		end
	end

	// interrupt enables
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			flash_config_reg <= `RST_CONFIG;
		end else if (wr_lane0 && wr_idx == `IDX_CONFIG) begin
			flash_config_reg <= wb & 8'hC0;
		end
	end

	// scenario index: polarity inverted into the top bit
	function automatic flash_ctl_pkg::scenario_t scen(
		input logic [7:0] p);
		scen = {!p[`PR_OPEN_POL], !p[`PR_HIGH_DIS], !p[`PR_LOW_DIS]};
	endfunction : scen

	// allowed moves; 6 and 7 may only be kept as they are
	function automatic logic move_ok(input flash_ctl_pkg::scenario_t f,
		input flash_ctl_pkg::scenario_t t);
		case (f)
			3'd0: move_ok = (t <= 3'd3);
			3'd1: move_ok = (t == 3'd1) || (t == 3'd3);
			3'd2: move_ok = (t == 3'd2) || (t == 3'd3);
			3'd3: move_ok = (t == 3'd3);
			3'd4: move_ok = (t == 3'd3) || (t == 3'd4);
			3'd5: move_ok = (t >= 3'd2) && (t <= 3'd5);
			default: move_ok = (t == f);
		endcase
	endfunction : move_ok

	// a write that would remove protection is dropped silently
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			protection_config <= `RST_PROTECT;
		end else if (wr_lane0 && wr_idx == `IDX_PROTECT
			&& move_ok(scen(protection_config), scen(wb))) begin
			protection_config <= wb;
		end
	end

	logic cmd_legal;
	logic prog_or_erase;
	logic blocked;
	logic launch_try;
	logic launch;
	logic seq_fault;
	logic code_fault;
	logic viol_hit;
	logic transfer;
	assign cmd_legal = (command_code_reg == `CMD_ERASE_VERIFY)
		|| (command_code_reg == `CMD_WORD_PROGRAM)
		|| (command_code_reg == `CMD_SECTOR_ERASE)
		|| (command_code_reg == `CMD_MASS_ERASE);
	assign prog_or_erase = (command_code_reg != `CMD_ERASE_VERIFY);
	assign blocked = protect_violation_flag || access_error_flag
		|| (special_mode && fail_flag);
	assign launch_try = seq_state == flash_ctl_pkg::seq_cmd && st_wr
		&& wb[`ST_BUF_EMPTY] && buf_empty_flag;
	// bad code or missing divider is an error, not an operation
	assign code_fault = launch_try && (!cmd_legal || !div_loaded);
	assign viol_hit = launch_try && !code_fault && !blocked
		&& cmd_legal && prog_or_erase && prot_hit;
	assign launch = launch_try && !code_fault && !blocked && !viol_hit;

	// any write other than the next expected step breaks the sequence
	always_comb begin
		seq_fault = 1'b0;
		case (seq_state)
			flash_ctl_pkg::seq_idle: begin
				seq_fault = cmd_wr
					|| (st_wr && wb[`ST_BUF_EMPTY] && buf_empty_flag);
			end
			flash_ctl_pkg::seq_addr: begin
				seq_fault = flash_wr || other_wr || st_wr;
			end
			flash_ctl_pkg::seq_cmd: begin
				seq_fault = flash_wr || other_wr || cmd_wr
					|| (st_wr && !wb[`ST_BUF_EMPTY])
					|| (st_wr && !buf_empty_flag);
			end
			default: seq_fault = 1'b0;
		endcase
	end

	// sequence tracker; ends on launch, refusal or fault
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			seq_state <= flash_ctl_pkg::seq_idle;
		end else begin
			case (seq_state)
				flash_ctl_pkg::seq_idle: begin
					if (flash_wr) begin
						seq_state <= flash_ctl_pkg::seq_addr;
					end
				end
				flash_ctl_pkg::seq_addr: begin
					if (seq_fault) begin
						seq_state <= flash_ctl_pkg::seq_idle;
					end else if (cmd_wr) begin
						seq_state <= flash_ctl_pkg::seq_cmd;
					end
				end
				flash_ctl_pkg::seq_cmd: begin
					if (seq_fault || st_wr) begin
						seq_state <= flash_ctl_pkg::seq_idle;
					end
				end
				default: seq_state <= flash_ctl_pkg::seq_idle;
			endcase
		end
	end

	// address, data and command buffer stage
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			seq_addr_out <= 13'h0000;
			seq_data <= 32'h0000_0000;
			command_code_reg <= 8'h00;
		end else begin
			if (flash_wr && seq_state == flash_ctl_pkg::seq_idle) begin
				seq_addr_out <= aw_addr;
				seq_data <= w_data;
			end
			if (cmd_wr && seq_state == flash_ctl_pkg::seq_addr) begin
				command_code_reg <= wb & `CMD_MASK;
			end
		end
	end

	// buffered command moves on when the engine is free or finishing
	assign transfer = !buf_empty_flag && (!op_active || op_done);

	// active stage toward the engine
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			op_active <= 1'b0;
			op_start <= 1'b0;
			op_code <= 8'h00;
			op_addr <= 13'h0000;
			op_data <= 32'h0000_0000;
		end else begin
			op_start <= transfer;
			if (transfer) begin
				op_active <= 1'b1;
				op_code <= command_code_reg;
				op_addr <= seq_addr_out;
				op_data <= seq_data;
			end else if (op_done) begin
				op_active <= 1'b0;
			end
		end
	end

	// empty flag: cleared by a valid launch, set when buffer drains
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			buf_empty_flag <= 1'b1;
		end else if (launch) begin
			buf_empty_flag <= 1'b0;
		end else if (transfer) begin
			buf_empty_flag <= 1'b1;
		end
	end

	// complete flag: no set while a buffered command takes over
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			command_complete_flag <= 1'b1;
		end else if (launch) begin
			command_complete_flag <= 1'b0;
		end else if (op_done && op_active && buf_empty_flag) begin
			command_complete_flag <= 1'b1;
		end
	end

	// violation flag; a new hit wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			protect_violation_flag <= 1'b0;
		end else if (viol_hit) begin
			protect_violation_flag <= 1'b1;
		end else if (st_wr && wb[`ST_PROT_VIOL]) begin
			protect_violation_flag <= 1'b0;
		end
	end

	// access error: zero writes have no effect; set beats clear
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			access_error_flag <= 1'b0;
		end else if (seq_fault || code_fault
			|| (stop_req && !command_complete_flag)) begin
			access_error_flag <= 1'b1;
		end else if (st_wr && wb[`ST_ACC_ERR]) begin
			access_error_flag <= 1'b0;
		end
	end

	logic verify_end;
	assign verify_end = op_done && op_active
		&& op_code == `CMD_ERASE_VERIFY;

	// blank flag is read-only; a fresh valid launch clears it
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			blank_flag <= 1'b0;
		end else if (verify_end && verify_blank) begin
			blank_flag <= 1'b1;
		end else if (launch) begin
			blank_flag <= 1'b0;
		end
	end

	// fail flag only acts in special modes
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			fail_flag <= 1'b0;
		end else if (special_mode && verify_end && !verify_blank) begin
			fail_flag <= 1'b1;
		end else if (special_mode && st_wr && wb[`ST_FAIL]) begin
			fail_flag <= 1'b0;
		end
	end

	logic [7:0] status_view;
	// normal modes hide fail and done; reserved bit 3 reads zero
	always_comb begin
		status_view = 8'h00;
		status_view[`ST_BUF_EMPTY] = buf_empty_flag;
		status_view[`ST_COMPLETE] = command_complete_flag;
		status_view[`ST_PROT_VIOL] = protect_violation_flag;
		status_view[`ST_ACC_ERR] = access_error_flag;
		status_view[`ST_BLANK] = blank_flag;
		if (special_mode) begin
			status_view[`ST_FAIL] = fail_flag;
			status_view[`ST_DONE] = !op_active;
		end
	end

	assign irq = (buf_empty_flag && flash_config_reg[`CFG_BUF_EMPTY_IE])
		|| (command_complete_flag
		&& flash_config_reg[`CFG_COMPLETE_IE]);

	logic [3:0] rd_idx;
	logic rd_ok;
	logic [7:0] rd_byte;
	assign rd_idx = s_axi_araddr[5:2];
	// read mux; flash window reads zero since the array lives elsewhere
	always_comb begin
		rd_ok = 1'b1;
		rd_byte = 8'h00;
		if (s_axi_araddr[`FLASH_SPACE_BIT]) begin
			rd_byte = 8'h00;
		end else if (s_axi_araddr[11:6] != 6'h00) begin
			rd_ok = 1'b0;
		end else begin
			case (rd_idx)
				`IDX_CLK_DIV: rd_byte = {div_loaded, flash_clock_divider};
				`IDX_CONFIG: rd_byte = flash_config_reg;
				`IDX_PROTECT: rd_byte = protection_config;
				`IDX_STATUS: rd_byte = status_view;
				`IDX_COMMAND: rd_byte = command_code_reg & `CMD_MASK;
				`IDX_RESERVED: rd_byte = 8'h00;
				default: rd_ok = 1'b0;
			endcase
		end
	end

	assign s_axi_arready = !s_axi_rvalid;
	// reads answer one cycle after the address is taken
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : flash_cmd_status_protect

// ==== sim/flash_cmd_status_protect_asserts.sv ====
`timescale 1ns/1ps

module flash_cmd_status_protect_asserts (
	input wire logic clk_sys, // clock
	input wire logic rst_n, // reset, active low
	input wire logic [12:0] s_axi_awaddr, // aw addr
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic [31:0] s_axi_wdata, // w data
	input wire logic [3:0] s_axi_wstrb, // w strobes
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic [1:0] s_axi_bresp, // b resp
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic [12:0] s_axi_araddr, // ar addr
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic [1:0] s_axi_rresp, // r resp
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic special_mode, // mode
	input wire logic stop_req, // stop pulse
	input wire logic prot_hit, // protected range
	input wire logic op_done, // engine done
	input wire logic verify_blank, // verify result
	input wire logic op_start, // launch pulse
	input wire logic [7:0] op_code, // active code
	input wire logic [12:0] op_addr, // active address
	input wire logic [31:0] op_data, // active data
	input wire logic op_active, // engine busy
	input wire logic [12:0] seq_addr_out, // captured address
	input wire logic [7:0] protection_config, // protection byte
	input wire logic irq // interrupt
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// one bit per from/to scenario pair, a byte per source scenario
	function automatic logic ok_move(input logic [7:0] a, b);
		logic [63:0] tbl = 64'h8040_3C18_080C_0A0F;
		return tbl[{!a[7], !a[5], !a[2], !b[7], !b[5], !b[2]}];
	endfunction : ok_move

	a_prot_tighten: assert property (
		$changed(protection_config) |->
		ok_move($past(protection_config), protection_config))
		else $error("protection moved to a looser scenario");
	a_prot_by_write: assert property (
		$changed(protection_config) |-> $rose(s_axi_bvalid))
		else $error("protection changed without a write");
	a_code_legal: assert property (
		op_start |-> op_code inside {8'h05, 8'h20, 8'h40, 8'h41})
		else $error("illegal code launched");
	a_start_active: assert property (op_start |-> op_active)
		else $error("launch without active engine");
	a_start_pulse: assert property (op_start |=> !op_start)
		else $error("launch pulse too long");
	// a transfer replaces the operation, so only hold between launches
	a_op_hold: assert property (op_active && !op_start |->
		$stable(op_code) && $stable(op_addr) && $stable(op_data))
		else $error("active operation changed");
	a_write_resp: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response missing");
	a_read_resp: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer missing");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
endmodule : flash_cmd_status_protect_asserts

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`include "flash_ctl_defines.svh"

module testbench;
	logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, special_mode;
	logic stop_req, prot_hit, op_done, verify_blank, op_start;
	logic op_active, irq;
	logic [12:0] s_axi_awaddr, s_axi_araddr, op_addr, seq_addr_out;
	logic [31:0] s_axi_wdata, s_axi_rdata, op_data, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0] op_code, protection_config, pm;
	logic [7:0] q [$];
	int fail_count, checked, cyc, n;
	localparam logic [12:0] DIV = 13'(`IDX_CLK_DIV) << 2;
	localparam logic [12:0] CFG = 13'(`IDX_CONFIG) << 2;
	localparam logic [12:0] PROT = 13'(`IDX_PROTECT) << 2;
	localparam logic [12:0] ST = 13'(`IDX_STATUS) << 2;
	localparam logic [12:0] CMD = 13'(`IDX_COMMAND) << 2;
	localparam logic [12:0] RSV = 13'(`IDX_RESERVED) << 2;
	localparam logic [7:0] CL [4] = '{`CMD_ERASE_VERIFY,
		`CMD_WORD_PROGRAM, `CMD_SECTOR_ERASE, `CMD_MASS_ERASE};

	flash_cmd_status_protect flash_cmd_status_protect_inst (.*);

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// launches logged at negedge, clear of the update edge; hang cutoff
	always @(negedge clk_sys) begin
		cyc++;
		if (op_start === 1'b1) q.push_back(op_code);
		if (cyc == 20000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// ready sampled at negedge so the release never races the edge
	task automatic wr(input logic [12:0] a, input logic [31:0] v,
		input logic [3:0] s);
		logic ta, tw, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clk_sys);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk_sys);
			if (ta && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (tw && s_axi_wvalid) s_axi_wvalid <= 1'b0;
		end while (!tb);
		// bready stays high: a next call never lowers and raises it at once
	endtask : wr

	task automatic rc(input logic [12:0] a, input logic [7:0] e);
		logic t, v;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk_sys);
			t = s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk_sys);
			if (t) s_axi_arvalid <= 1'b0;
		end while (!v);
		chk($sformatf("reg %h", a), d, {24'h0, e});
	endtask : rc

	task automatic rst();
		rst_n <= 1'b0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		pm = 8'hFF;
	endtask : rst

	// flash word, then code, then launch write, no writes between
	task automatic go(input logic [7:0] c, l, input int k);
		logic [12:0] fa;
		logic [31:0] fd;
		fa = {1'b1, 10'($urandom), 2'b00};
		fd = $urandom;
		n = q.size();
		wr(fa, fd, 4'hF);
		chk("captured", seq_addr_out, fa);
		wr(CMD, {24'h0, c}, 4'h1);
		wr(ST, {24'h0, l}, 4'h1);
		repeat (3) @(posedge clk_sys);
		chk("starts", q.size(), n + k);
		// a launched command carries the address and data of its step one
		if (k == 1) begin
			chk("op addr", op_addr, fa);
			chk("op data", op_data, fd);
		end
	endtask : go

	task automatic pulse(input logic s, b);
		stop_req <= s;
		op_done <= !s;
		verify_blank <= b;
		@(posedge clk_sys);
		{stop_req, op_done} <= 2'b00;
		@(posedge clk_sys);
	endtask : pulse

	task automatic ci(input logic e);
		@(negedge clk_sys);
		chk("irq", irq, e);
		@(posedge clk_sys);
	endtask : ci

	// model of the scenario table; spare bits random
	function automatic logic ok(input logic [7:0] a, b);
		logic [63:0] tbl = 64'h8040_3C18_080C_0A0F;
		return tbl[{!a[7], !a[5], !a[2], !b[7], !b[5], !b[2]}];
	endfunction : ok

	task automatic pw(input logic [2:0] t);
		logic [7:0] b;
		b = {!t[2], 1'b0, !t[1], 2'b00, !t[0], 2'b00};
		b = b | (8'($urandom) & 8'h5B);
		wr(PROT, {24'h0, b}, 4'h1);
		if (ok(pm, b)) pm = b;
		rc(PROT, pm);
		chk("protection", protection_config, pm);
	endtask : pw

	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
			s_axi_rready, special_mode, stop_req, prot_hit, op_done,
			verify_blank, s_axi_awaddr, s_axi_araddr, s_axi_wdata,
			s_axi_wstrb} = '0;
		void'($urandom(32'h6739f428));
		rst();
		rc(ST, 8'hC0);
		rc(RSV, 8'h00);
		wr(13'h0008, 32'hFF, 4'h1);
		chk("bresp", rsp, `RESP_SLVERR);
		rc(13'h0008, 8'h00);
		chk("rresp", rsp, `RESP_SLVERR);
		$display("test reset done");
		for (int t = 0; t < 8; t++) begin
			rst();
			pw(3'(t));
			for (int u = 0; u < 8; u++)
				pw(3'(u));
		end
		$display("test protection done");
		rst();
		go(`CMD_WORD_PROGRAM, 8'h80, 0);
		rc(ST, 8'hD0);
		wr(ST, 32'h10, 4'h1);
		wr(DIV, 32'h01, 4'h1);
		special_mode <= 1'b1;
		foreach (CL[i]) begin
			go(CL[i], 8'h80, 1);
			chk("code", q[$], CL[i]);
			rc(ST, 8'h80);
			pulse(1'b0, 1'b1);
			rc(ST, CL[i] == 8'h05 ? 8'hC5 : 8'hC1);
		end
		go(`CMD_ERASE_VERIFY, 8'h80, 1);
		pulse(1'b0, 1'b0);
		rc(ST, 8'hC3);
		go(`CMD_WORD_PROGRAM, 8'h80, 0);
		wr(ST, 32'h02, 4'h1);
		rc(ST, 8'hC1);
		special_mode <= 1'b0;
		wr(ST, 32'h46, 4'h1);
		rc(ST, 8'hC0);
		$display("test commands done");
		wr(13'h1000, 32'h1234, 4'hF);
		wr(CMD, 32'hFF, 4'h1);
		rc(CMD, 8'h65);
		n = q.size();
		wr(ST, 32'h80, 4'h1);
		repeat (3) @(posedge clk_sys);
		chk("starts", q.size(), n);
		rc(ST, 8'hD0);
		go(`CMD_WORD_PROGRAM, 8'h80, 0);
		wr(ST, 32'h00, 4'h1);
		rc(ST, 8'hD0);
		wr(ST, 32'h10, 4'h1);
		wr(13'h1004, 32'h5678, 4'hF);
		wr(ST, 32'h00, 4'h1);
		rc(ST, 8'hD0);
		wr(ST, 32'h10, 4'h1);
		rc(ST, 8'hC0);
		wr(CMD, 32'h20, 4'h1);
		rc(ST, 8'hD0);
		wr(ST, 32'h10, 4'h1);
		prot_hit <= 1'b1;
		go(`CMD_SECTOR_ERASE, 8'h80, 0);
		prot_hit <= 1'b0;
		go(`CMD_WORD_PROGRAM, 8'h80, 0);
		rc(ST, 8'hE0);
		wr(ST, 32'h20, 4'h1);
		rc(ST, 8'hC0);
		$display("test errors done");
		go(`CMD_WORD_PROGRAM, 8'h80, 1);
		go(`CMD_SECTOR_ERASE, 8'h80, 0);
		rc(ST, 8'h00);
		wr(CFG, 32'h80, 4'h1);
		ci(1'b0);
		pulse(1'b0, 1'b0);
		chk("starts", q.size(), n + 1);
		chk("code", q[$], `CMD_SECTOR_ERASE);
		rc(ST, 8'h80);
		ci(1'b1);
		wr(CFG, 32'h40, 4'h1);
		ci(1'b0);
		pulse(1'b1, 1'b0);
		rc(ST, 8'h90);
		pulse(1'b0, 1'b0);
		rc(ST, 8'hD0);
		ci(1'b1);
		wr(ST, 32'h10, 4'h1);
		pulse(1'b1, 1'b0);
		rc(ST, 8'hC0);
		wr(CFG, 32'h00, 4'h1);
		ci(1'b0);
		$display("test pipeline done");
		wrap_up();
	end
endmodule : testbench

bind flash_cmd_status_protect flash_cmd_status_protect_asserts
	asserts_inst (.*);
